// *** hdl/obslc_cfg.svh ***
// constants for the offset and bit-sync loop control block
`ifndef OBSLC_CFG_SVH
`define OBSLC_CFG_SVH
// register offsets
`define OBSLC_FOC_ADDR 6'h19
`define OBSLC_BS_ADDR 6'h1A
// reset values
`define OBSLC_FOC_RST 8'h36
`define OBSLC_BS_RST 8'h6C
// field positions, frequency register
`define OBSLC_FOC_GATE_BIT 5
`define OBSLC_FOC_PRE_HI 4
`define OBSLC_FOC_PRE_LO 3
`define OBSLC_FOC_POST_BIT 2
`define OBSLC_FOC_LIM_HI 1
`define OBSLC_FOC_LIM_LO 0
`define OBSLC_FOC_WMASK 8'h3F
// field positions, bit-sync register
`define OBSLC_BS_KI_HI 7
`define OBSLC_BS_KI_LO 6
`define OBSLC_BS_KP_HI 5
`define OBSLC_BS_KP_LO 4
`define OBSLC_BS_POSTKI_BIT 3
`define OBSLC_BS_POSTKP_BIT 2
`define OBSLC_BS_LIM_HI 1
`define OBSLC_BS_LIM_LO 0
`endif

// *** hdl/obslc_pkg.sv ***
// types for the offset and bit-sync loop control block
package obslc_pkg;
  // gain expressed in half units of the base gain: 1 = K/2 .. 8 = 4K
  typedef logic [3:0] obslc_gain_t;
  // loop settings handed to the demodulator datapath
  typedef struct packed {
    logic freq_run;
    obslc_gain_t freq_gain;
    logic [1:0] freq_offset_saturation;
    logic clkrec_run;
    obslc_gain_t clkrec_integral;
    obslc_gain_t clkrec_proportional;
    logic [1:0] rate_offset_saturation;
  } obslc_loop_t;
  // sync-phase tracker states
  typedef enum logic [1:0] {
    OBSLC_PRE = 2'b01,
    OBSLC_POST = 2'b10
  } obslc_phase_t;
endpackage

// *** hdl/obslc_gain_map.sv ***
// maps a pre/post gain selection to half-unit gain
`timescale 1ns/100ps
`default_nettype none
module obslc_gain_map (
  input wire logic [1:0] pre_sel,
  input wire logic post_bit,
  input wire logic after_sync,
  input wire logic post_is_base,
  output logic [3:0] gain
);
  // pre gain: code n gives (n+1) base units = 2(n+1) half units
  logic [3:0] pre_gain;
  always_comb begin
    pre_gain = {1'b0, pre_sel, 1'b0} + 4'h2;
    gain = pre_gain;
    // post selection replaces pre gain once the sync word is seen
    if (after_sync && post_bit) begin
      gain = post_is_base ? 4'h2 : 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** hdl/obslc_top.sv ***
// offset compensation and bit-sync loop control with register port
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "obslc_cfg.svh"
module obslc_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic carrier_sense,
  input wire logic sync_detected,
  input wire logic rx_restart,
  output obslc_pkg::obslc_loop_t loop_cfg
);
  import obslc_pkg::*;

  // configuration registers
  logic [7:0] foc_q;
  logic [7:0] bs_q;
  // synchronised demodulator status
  logic [1:0] cs_sync_q;
  logic [1:0] sync_sync_q;
  logic [1:0] rst_sync_q;
  // sync phase and gate state
  obslc_phase_t phase_q;
  logic sensed_q;
  // gain map results
  obslc_gain_t freq_gain;
  obslc_gain_t ki_gain;
  obslc_gain_t kp_gain;
  logic after_sync;
  logic gate_hold;
  // per-register hit, qualified by the strobe that uses it
  logic [1:0] wr_sel;
  logic [1:0] rd_sel;

  // register address decode, used for writes and reads
  function automatic logic [1:0] decode(input logic [5:0] a);
    decode = {a == `OBSLC_BS_ADDR, a == `OBSLC_FOC_ADDR};
  endfunction

  // a function result cannot be bit-selected, so the hits live in nets
  assign wr_sel = decode(reg_addr) & {2{reg_wr}};
  assign rd_sel = decode(reg_addr) & {2{reg_rd}};

  // register writes; unused frequency bits 7:6 stay zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      foc_q <= `OBSLC_FOC_RST;
      bs_q <= `OBSLC_BS_RST;
    end else if (clk_en) begin
      if (wr_sel[0]) begin
        foc_q <= reg_wdata & `OBSLC_FOC_WMASK;
      end
      if (wr_sel[1]) begin
        bs_q <= reg_wdata;
      end
    end
  end

  // read data one cycle later; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (rd_sel[0]) begin
        reg_rdata <= foc_q;
      end else if (rd_sel[1]) begin
        reg_rdata <= bs_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // two-stage synchronisers for demodulator status levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_q <= 2'b00;
      sync_sync_q <= 2'b00;
      rst_sync_q <= 2'b00;
    end else if (clk_en) begin
      cs_sync_q <= {cs_sync_q[0], carrier_sense};
      sync_sync_q <= {sync_sync_q[0], sync_detected};
      rst_sync_q <= {rst_sync_q[0], rx_restart};
    end
  end

  // sync phase: restart wins, then sync detection moves to post gains
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= OBSLC_PRE;
    end else if (clk_en) begin
      unique case (phase_q)
        OBSLC_PRE: begin
          if (!rst_sync_q[1] && sync_sync_q[1]) begin
            phase_q <= OBSLC_POST;
          end
        end
        OBSLC_POST: begin
          if (rst_sync_q[1]) begin
            phase_q <= OBSLC_PRE;
          end
        end
        default: begin
          phase_q <= OBSLC_PRE;
        end
      endcase
    end
  end

  // carrier sense seen in this attempt; cleared on restart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sensed_q <= 1'b0;
    end else if (clk_en) begin
      if (rst_sync_q[1]) begin
        sensed_q <= 1'b0;
      end else if (cs_sync_q[1]) begin
        sensed_q <= 1'b1;
      end
    end
  end

  assign after_sync = (phase_q == OBSLC_POST);
  // loops held while gate set and no carrier sense yet
  assign gate_hold = foc_q[`OBSLC_FOC_GATE_BIT] && !sensed_q && !cs_sync_q[1];

  // frequency loop gain: pre K..4K, post same or K/2
  obslc_gain_map u_freq_gain (
    .pre_sel(foc_q[`OBSLC_FOC_PRE_HI:`OBSLC_FOC_PRE_LO]),
    .post_bit(foc_q[`OBSLC_FOC_POST_BIT]),
    .after_sync(after_sync),
    .post_is_base(1'b0),
    .gain(freq_gain)
  );

  // clock recovery integral gain: pre Ki..4Ki, post same or Ki/2
  obslc_gain_map u_ki_gain (
    .pre_sel(bs_q[`OBSLC_BS_KI_HI:`OBSLC_BS_KI_LO]),
    .post_bit(bs_q[`OBSLC_BS_POSTKI_BIT]),
    .after_sync(after_sync),
    .post_is_base(1'b0),
    .gain(ki_gain)
  );

  // clock recovery proportional gain: pre Kp..4Kp, post same or Kp
  obslc_gain_map u_kp_gain (
    .pre_sel(bs_q[`OBSLC_BS_KP_HI:`OBSLC_BS_KP_LO]),
    .post_bit(bs_q[`OBSLC_BS_POSTKP_BIT]),
    .after_sync(after_sync),
    .post_is_base(1'b1),
    .gain(kp_gain)
  );

  // registered loop settings to the datapath
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_cfg <= '0;
    end else if (clk_en) begin
      loop_cfg.freq_run <= !gate_hold;
      loop_cfg.clkrec_run <= !gate_hold;
      loop_cfg.freq_gain <= freq_gain;
      loop_cfg.clkrec_integral <= ki_gain;
      loop_cfg.clkrec_proportional <= kp_gain;
      // code 0 means no compensation, 1..3 are BW/8, BW/4, BW/2
      loop_cfg.freq_offset_saturation <= foc_q[`OBSLC_FOC_LIM_HI:`OBSLC_FOC_LIM_LO];
      // code 0 none, 1..3 are 3.125, 6.25, 12.5 percent
      loop_cfg.rate_offset_saturation <= bs_q[`OBSLC_BS_LIM_HI:`OBSLC_BS_LIM_LO];
    end
  end
endmodule
`default_nettype wire

// *** tb/obslc_assertions.sv ***
// port checker for the loop control block
`timescale 1ns/100ps
`default_nettype none
module obslc_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire obslc_pkg::obslc_loop_t loop_cfg
);
  import obslc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // read data is zero unless a read was taken
  property p_rd_idle;
    clk_en && !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  // unmapped reads return zero
  property p_unmapped;
    clk_en && reg_rd && !(reg_addr inside {6'h19, 6'h1A}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // bit-sync write reads back whole
  property p_wr_rd;
    clk_en && reg_wr && reg_addr == 6'h1A ##1 clk_en && reg_rd && reg_addr == 6'h1A
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback wrong");
  // saturation codes reach the loops two cycles on
  property p_fsat;
    clk_en && reg_wr && reg_addr == 6'h19 ##1 clk_en
      |=> loop_cfg.freq_offset_saturation == $past(reg_wdata[1:0], 2);
  endproperty
  a_fsat: assert property (p_fsat) else $error("freq limit wrong");
  property p_rsat;
    clk_en && reg_wr && reg_addr == 6'h1A ##1 clk_en
      |=> loop_cfg.rate_offset_saturation == $past(reg_wdata[1:0], 2);
  endproperty
  a_rsat: assert property (p_rsat) else $error("rate limit wrong");
  // with post bit clear the gain is the pre-sync gain in any phase
  property p_fgain;
    clk_en && reg_wr && reg_addr == 6'h19 && !reg_wdata[2] ##1 clk_en
      |=> loop_cfg.freq_gain == {$past(reg_wdata[4:3], 2), 1'b0} + 4'h2;
  endproperty
  a_fgain: assert property (p_fgain) else $error("freq gain wrong");
  property p_bsgain;
    clk_en && reg_wr && reg_addr == 6'h1A && reg_wdata[3:2] == 2'h0 ##1 clk_en
      |=> loop_cfg.clkrec_integral == {$past(reg_wdata[7:6], 2), 1'b0} + 4'h2
      && loop_cfg.clkrec_proportional == {$past(reg_wdata[5:4], 2), 1'b0} + 4'h2;
  endproperty
  a_bsgain: assert property (p_bsgain) else $error("clock gains wrong");
  // both loops are gated together
  property p_gate;
    loop_cfg.freq_run == loop_cfg.clkrec_run;
  endproperty
  a_gate: assert property (p_gate) else $error("loops gated apart");
  // proportional gain never drops below base
  property p_kp;
    $past(rst_b) |-> loop_cfg.clkrec_proportional inside {4'h2, 4'h4, 4'h6, 4'h8};
  endproperty
  a_kp: assert property (p_kp) else $error("prop gain illegal");
endmodule
bind obslc_top obslc_assertions u_chk (.*);
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the loop control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import obslc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic carrier_sense = 1'b0;
  logic sync_detected = 1'b0;
  logic rx_restart = 1'b0;
  logic clk_en = 1'b1;
  logic rd_q = 1'b0;
  logic [7:0] reg_rdata;
  obslc_loop_t loop_cfg;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0001454D;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  obslc_top dut (.clk, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .carrier_sense, .sync_detected, .rx_restart, .loop_cfg);
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one bus cycle; reads note their expected data
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  // read data monitor and hang limit
  always @(posedge clk) begin
    rd_q <= reg_rd;
    cyc <= cyc + 1;
    if (rd_q) chk(reg_rdata, exp_q.pop_front());
    if (cyc > 2000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    logic [7:0] d;
    logic [5:0] a;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    idle(2);
    chk(loop_cfg, {1'b0, 4'h6, 2'h2, 1'b0, 4'h4, 4'h6, 2'h0});
    bus(1'b0, 6'h19, 8'h36);
    bus(1'b0, 6'h1A, 8'h6C);
    bus(1'b0, 6'h3F, 8'h00);
    for (int i = 0; i < 24; i++) begin
      d = 8'(rnd());
      a = i[0] ? 6'h1A : 6'h19;
      bus(1'b1, a, d);
      bus(1'b0, a, a == 6'h19 ? d & 8'h3F : d);
    end
    bus(1'b1, 6'h19, 8'h3E);
    bus(1'b1, 6'h1A, 8'hFC);
    idle(2);
    chk({loop_cfg.freq_run, loop_cfg.freq_gain, loop_cfg.clkrec_integral,
      loop_cfg.clkrec_proportional}, 13'h0888);
    carrier_sense <= 1'b1;
    idle(5);
    chk({loop_cfg.freq_run, loop_cfg.clkrec_run}, 2'h3);
    sync_detected <= 1'b1;
    idle(5);
    chk({loop_cfg.freq_gain, loop_cfg.clkrec_integral, loop_cfg.clkrec_proportional},
      12'h112);
    sync_detected <= 1'b0;
    carrier_sense <= 1'b0;
    rx_restart <= 1'b1;
    idle(5);
    rx_restart <= 1'b0;
    chk({loop_cfg.freq_run, loop_cfg.freq_gain, loop_cfg.clkrec_integral,
      loop_cfg.clkrec_proportional}, 13'h0888);
    bus(1'b1, 6'h19, 8'h1E);
    idle(2);
    chk(loop_cfg.freq_run, 1'b1);
    // software keeps freq saturation at zero for amplitude keying
    bus(1'b1, 6'h19, 8'h1C);
    idle(2);
    chk(loop_cfg.freq_offset_saturation, 2'h0);
    // a write while the clock enable is low must be lost
    clk_en <= 1'b0;
    bus(1'b1, 6'h1A, 8'h00);
    clk_en <= 1'b1;
    bus(1'b0, 6'h1A, 8'hFC);
    idle(2);
    chk(loop_cfg.clkrec_integral, 4'h8);
    stop_test();
  end
endmodule
`default_nettype wire
